// ==== verilog/sse_map.svh ====
// Offsets, field positions, reset values and sense codes of the encoder
`ifndef SSE_MAP_SVH
`define SSE_MAP_SVH
// Register byte addresses
`define SSE_CTRL_ADDR    8'h00
`define SSE_KEYS_ADDR    8'h04
`define SSE_SPEC_ADDR    8'h08
// Control register fields
`define SSE_CTRL_SUPER   0
`define SSE_CTRL_CLEAR   1
`define SSE_CTRL_RESET   1'h0
// Byte 15 field positions
`define SSE_B15_SPEC_VLD 7
`define SSE_B15_CMD      6
`define SSE_B15_BIT_VLD  3
// Sense keys
`define SSE_KEY_NONE     4'h0
`define SSE_KEY_RECOV    4'h1
// Additional sense code and qualifier pairs
`define SSE_Q_NONE       16'h0000
`define SSE_Q_WR_REALLOC 16'h0C01
`define SSE_Q_SEEK       16'h0200
`define SSE_Q_PREAMP     16'h0300
`define SSE_Q_SERVO_WF   16'h0396
`define SSE_Q_WEDGE      16'h0397
`define SSE_Q_SV_COMM    16'h0980
`define SSE_Q_SV_QUIT    16'h0981
`define SSE_Q_ID_CRC     16'h1000
`define SSE_Q_ID_AM      16'h1200
`define SSE_Q_DATA_AM    16'h1300
`define SSE_Q_ENTITY     16'h1401
`define SSE_Q_RND_POS    16'h1500
`define SSE_Q_NO_CORR    16'h1701
`define SSE_Q_OFFTRACK   16'h1702
`define SSE_Q_ECC_CORR   16'h1800
`define SSE_Q_ECC_LAST   16'h1801
`define SSE_Q_RD_REALLOC 16'h1802
`define SSE_Q_HEAD_MIS   16'h448A
`define SSE_Q_SEQ_ERR    16'h4486
`define SSE_Q_SEQ_TMO    16'h4495
`define SSE_Q_UNDERRUN   16'h4497
`define SSE_Q_FMT_NA     16'h1C00
`define SSE_Q_OTF_ECC    16'hAF00
`endif

// ==== verilog/sse_pkg.sv ====
// Types shared by the sense-specific encoder
`default_nettype none
package sse_pkg;
	// Internal error events, one code each
	typedef enum logic [4:0] {
		SSE_EV_NONE       = 5'h00,
		SSE_EV_WR_REALLOC = 5'h01,
		SSE_EV_SEEK       = 5'h02,
		SSE_EV_PREAMP     = 5'h03,
		SSE_EV_SERVO_WF   = 5'h04,
		SSE_EV_WEDGE      = 5'h05,
		SSE_EV_SV_COMM    = 5'h06,
		SSE_EV_SV_QUIT    = 5'h07,
		SSE_EV_ID_CRC     = 5'h08,
		SSE_EV_ID_AM      = 5'h09,
		SSE_EV_DATA_AM    = 5'h0A,
		SSE_EV_ENTITY     = 5'h0B,
		SSE_EV_RND_POS    = 5'h0C,
		SSE_EV_NO_CORR    = 5'h0D,
		SSE_EV_OFFTRACK   = 5'h0E,
		SSE_EV_ECC_CORR   = 5'h0F,
		SSE_EV_ECC_LAST   = 5'h10,
		SSE_EV_RD_REALLOC = 5'h11,
		SSE_EV_HEAD_MIS   = 5'h12,
		SSE_EV_SEQ_ERR    = 5'h13,
		SSE_EV_SEQ_TMO    = 5'h14,
		SSE_EV_UNDERRUN   = 5'h15,
		SSE_EV_FMT_NA     = 5'h16,
		SSE_EV_OTF_ECC    = 5'h17
	} sse_event_type;
endpackage
`default_nettype wire

// ==== verilog/sse_encoder.sv ====
// Sense key, code, qualifier and sense-key-specific byte encoder
`include "sse_map.svh"
`default_nettype none

module sse_encoder #(
	parameter int PTR_W = 16       // Field pointer and retry width
) (
	input  wire logic                 clk,
	input  wire logic                 rst,
	// Error event from drive logic
	input  wire logic                 ev_valid,
	input  wire sse_pkg::sse_event_type ev_id,
	// Field pointer information
	input  wire logic                 ptr_valid,
	input  wire logic                 ptr_cmd,
	input  wire logic [PTR_W-1:0]     ptr_first,
	input  wire logic [PTR_W-1:0]     ptr_last,
	input  wire logic                 bit_valid,
	input  wire logic [2:0]           bit_pos,
	// Retry count information
	input  wire logic                 retry_valid,
	input  wire logic [PTR_W-1:0]     retry_count,
	// Register port
	input  wire logic [7:0]           reg_addr,
	input  wire logic [31:0]          reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic      [31:0]          reg_rdata,
	// Sense bytes toward the data-in path
	output logic      [3:0]           sense_key,
	output logic      [7:0]           sense_code,
	output logic      [7:0]           sense_qual,
	output logic      [7:0]           sense_b15,
	output logic      [7:0]           sense_b16,
	output logic      [7:0]           sense_b17,
	output logic                      sense_update
);
	import sse_pkg::*;

	// ****************************************************
	// Declarations
	// ****************************************************
	logic              super_mode;      // Super mode enable
	logic              next_super_mode; // Next super mode
	logic [3:0]        next_key;        // Next sense key
	logic [15:0]       next_cq;         // Next code and qualifier
	logic [7:0]        next_b15;        // Next byte 15
	logic [15:0]       next_fld;        // Next bytes 16-17
	logic              next_update;     // Next update pulse
	logic [31:0]       next_rdata;      // Next read data
	logic [15:0]       cq_lookup;       // Decoded code pair
	logic [PTR_W-1:0]  ptr_lead;        // Leftmost pointer index
	logic              clr_req;         // Software clear request
	logic [15:0]       fld;             // Bytes 16-17 held

	// ****************************************************
	// Event decode
	// ****************************************************
	// Maps one event to exactly one code pair
	always_comb begin
		case (ev_id)
			SSE_EV_WR_REALLOC: cq_lookup = `SSE_Q_WR_REALLOC;
			SSE_EV_SEEK:       cq_lookup = `SSE_Q_SEEK;
			SSE_EV_PREAMP:     cq_lookup = `SSE_Q_PREAMP;
			SSE_EV_SERVO_WF:   cq_lookup = `SSE_Q_SERVO_WF;
			SSE_EV_WEDGE:      cq_lookup = `SSE_Q_WEDGE;
			SSE_EV_SV_COMM:    cq_lookup = `SSE_Q_SV_COMM;
			SSE_EV_SV_QUIT:    cq_lookup = `SSE_Q_SV_QUIT;
			SSE_EV_ID_CRC:     cq_lookup = `SSE_Q_ID_CRC;
			SSE_EV_ID_AM:      cq_lookup = `SSE_Q_ID_AM;
			SSE_EV_DATA_AM:    cq_lookup = `SSE_Q_DATA_AM;
			SSE_EV_ENTITY:     cq_lookup = `SSE_Q_ENTITY;
			SSE_EV_RND_POS:    cq_lookup = `SSE_Q_RND_POS;
			SSE_EV_NO_CORR:    cq_lookup = `SSE_Q_NO_CORR;
			SSE_EV_OFFTRACK:   cq_lookup = `SSE_Q_OFFTRACK;
			SSE_EV_ECC_CORR:   cq_lookup = `SSE_Q_ECC_CORR;
			SSE_EV_ECC_LAST:   cq_lookup = `SSE_Q_ECC_LAST;
			SSE_EV_RD_REALLOC: cq_lookup = `SSE_Q_RD_REALLOC;
			SSE_EV_HEAD_MIS:   cq_lookup = `SSE_Q_HEAD_MIS;
			SSE_EV_SEQ_ERR:    cq_lookup = `SSE_Q_SEQ_ERR;
			SSE_EV_SEQ_TMO:    cq_lookup = `SSE_Q_SEQ_TMO;
			SSE_EV_UNDERRUN:   cq_lookup = `SSE_Q_UNDERRUN;
			SSE_EV_FMT_NA:     cq_lookup = `SSE_Q_FMT_NA;
			// Outside super mode, fall back to ECC corrected
			SSE_EV_OTF_ECC: begin
				if (super_mode) begin
					cq_lookup = `SSE_Q_OTF_ECC;
				end else begin
					cq_lookup = `SSE_Q_ECC_CORR;
				end
			end
			// No event or unknown code reports no sense
			default:           cq_lookup = `SSE_Q_NONE;
		endcase
	end

	// Leftmost byte of a multi-byte item is the lower index
	assign ptr_lead = (ptr_last < ptr_first) ? ptr_last : ptr_first;

	// Software clear from the control register
	assign clr_req = reg_wr && (reg_addr == `SSE_CTRL_ADDR) &&
		reg_wdata[`SSE_CTRL_CLEAR];

	// ****************************************************
	// Sense state
	// ****************************************************
	// Next sense bytes; a new event wins over a clear
	always_comb begin
		next_key    = sense_key;
		next_cq     = {sense_code, sense_qual};
		next_b15    = sense_b15;
		next_fld    = fld;
		next_update = 1'b0;
		if (ev_valid) begin
			next_update = 1'b1;
			next_cq     = cq_lookup;
			next_b15    = 8'h00;
			next_fld    = 16'h0000;
			if (cq_lookup == `SSE_Q_NONE) begin
				// Nothing specific: plain no-sense report
				next_key = `SSE_KEY_NONE;
			end else begin
				// Completed after recovery
				next_key = `SSE_KEY_RECOV;
				if (ptr_valid) begin
					// Pointer into command or data-out bytes
					next_b15[`SSE_B15_SPEC_VLD] = 1'b1;
					next_b15[`SSE_B15_CMD]      = ptr_cmd;
					next_fld = 16'(ptr_lead);
					if (bit_valid) begin
						next_b15[`SSE_B15_BIT_VLD] = 1'b1;
						next_b15[2:0] = bit_pos;
					end
				end else if (retry_valid) begin
					// Retry count form: rest of byte 15 reserved
					next_b15[`SSE_B15_SPEC_VLD] = 1'b1;
					next_fld = 16'(retry_count);
				end
			end
		end else if (clr_req) begin
			// Software returns the record to no sense
			next_key = `SSE_KEY_NONE;
			next_cq  = `SSE_Q_NONE;
			next_b15 = 8'h00;
			next_fld = 16'h0000;
		end
	end

	// Registers the sense bytes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sense_key    <= `SSE_KEY_NONE;
			sense_code   <= 8'h00;
			sense_qual   <= 8'h00;
			sense_b15    <= 8'h00;
			fld          <= 16'h0000;
			sense_update <= 1'b0;
		end else begin
			sense_key    <= next_key;
			sense_code   <= next_cq[15:8];
			sense_qual   <= next_cq[7:0];
			sense_b15    <= next_b15;
			fld          <= next_fld;
			sense_update <= next_update;
		end
	end

	// Field split: byte 16 most significant
	assign sense_b16 = fld[15:8];
	assign sense_b17 = fld[7:0];

	// ****************************************************
	// Register port
	// ****************************************************
	// Next control and read data
	always_comb begin
		next_super_mode = super_mode;
		next_rdata      = 32'h0000_0000;
		if (reg_wr && (reg_addr == `SSE_CTRL_ADDR)) begin
			// Super mode select
			next_super_mode = reg_wdata[`SSE_CTRL_SUPER];
		end
		if (reg_rd) begin
			case (reg_addr)
				// Control readback; clear reads zero
				`SSE_CTRL_ADDR: begin
					next_rdata = {31'h0000_0000, super_mode};
				end
				// Key, code and qualifier
				`SSE_KEYS_ADDR: begin
					next_rdata = {8'h00, 4'h0, sense_key,
						sense_code, sense_qual};
				end
				// Bytes 15 to 17
				`SSE_SPEC_ADDR: begin
					next_rdata = {8'h00, sense_b15, fld};
				end
				// Unmapped reads zero
				default: begin
					next_rdata = 32'h0000_0000;
				end
			endcase
		end
	end

	// Registers control and read data
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			super_mode <= `SSE_CTRL_RESET;
			reg_rdata  <= 32'h0000_0000;
		end else begin
			super_mode <= next_super_mode;
			reg_rdata  <= next_rdata;
		end
	end

endmodule
`default_nettype wire

// ==== tb/sse_encoder_sva.sv ====
// Concurrent checks on the sense encoder ports
`default_nettype none
module sse_encoder_sva #(
	parameter int PTR_W = 16       // Pointer width
) (
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire logic                   ev_valid,
	input  wire sse_pkg::sse_event_type ev_id,
	input  wire logic                   ptr_valid,
	input  wire logic                   ptr_cmd,
	input  wire logic [PTR_W-1:0]       ptr_first,
	input  wire logic [PTR_W-1:0]       ptr_last,
	input  wire logic                   bit_valid,
	input  wire logic [2:0]             bit_pos,
	input  wire logic                   retry_valid,
	input  wire logic [PTR_W-1:0]       retry_count,
	input  wire logic [3:0]             sense_key,
	input  wire logic [7:0]             sense_code,
	input  wire logic [7:0]             sense_qual,
	input  wire logic [7:0]             sense_b15,
	input  wire logic [7:0]             sense_b16,
	input  wire logic [7:0]             sense_b17,
	input  wire logic                   sense_update
);
	import sse_pkg::*;
	logic [PTR_W-1:0] lead;        // Leftmost byte of the item
	assign lead = (ptr_first < ptr_last) ? ptr_first : ptr_last;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Event taken with a known recovered code
	sequence known_s;
		ev_valid && ev_id != SSE_EV_NONE && ev_id <= SSE_EV_OTF_ECC;
	endsequence
	// Answer one cycle later
	sequence upd_s;
		##1 sense_update;
	endsequence
	upd_pulse_a: assert property (ev_valid |-> upd_s)
		else $error("no update after event");
	quiet_out_a: assert property (!ev_valid |=> !sense_update)
		else $error("update without event");
	no_sense_a: assert property (ev_valid && ev_id == SSE_EV_NONE |=>
		{sense_key, sense_code, sense_qual} == 20'h00000)
		else $error("no-sense triple wrong");
	recov_key_a: assert property (known_s |=> sense_key == 4'h1)
		else $error("recovered key wrong");
	bit_ptr_a: assert property (known_s ##0 ptr_valid |=> sense_b15 ==
		{1'b1, $past(ptr_cmd), 2'b00, $past(bit_valid),
		$past(bit_valid) ? $past(bit_pos) : 3'h0})
		else $error("byte 15 wrong");
	field_ptr_a: assert property (known_s ##0 ptr_valid |=>
		{sense_b16, sense_b17} == $past(lead))
		else $error("field pointer wrong");
	retry_cnt_a: assert property (known_s ##0 !ptr_valid && retry_valid |=>
		sense_b15 == 8'h80 && {sense_b16, sense_b17} == $past(retry_count))
		else $error("retry count wrong");
	ptr_clear_a: assert property (known_s ##0 !ptr_valid && !retry_valid |=>
		{sense_b15, sense_b16, sense_b17} == 24'h000000)
		else $error("pointer bytes not cleared");
	seek_code_a: assert property (ev_valid && ev_id == SSE_EV_SEEK |=>
		{sense_code, sense_qual} == 16'h0200)
		else $error("seek code wrong");
endmodule
`default_nettype wire

// ==== tb/sse_initiator.sv ====
// Initiator model that collects each returned sense record
`default_nettype none
module sse_initiator (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        sense_update,
	input  wire logic [3:0]  sense_key,
	input  wire logic [7:0]  sense_code,
	input  wire logic [7:0]  sense_qual,
	input  wire logic [7:0]  sense_b15,
	input  wire logic [7:0]  sense_b16,
	input  wire logic [7:0]  sense_b17,
	output logic      [15:0] got_count,
	output logic      [43:0] last_sense
);
	timeunit 1ns;
	timeprecision 1ps;
	// Take the bytes whenever a new record is announced
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			got_count <= 16'h0000;
			last_sense <= 44'h0;
		end else if (sense_update) begin
			got_count <= got_count + 16'h0001;
			last_sense <= {sense_key, sense_code, sense_qual,
				sense_b15, sense_b16, sense_b17};
		end
	end
endmodule
`default_nettype wire

// ==== tb/sse_encoder_bench.sv ====
// Self-checking bench of the sense encoder
`default_nettype none
module sse_encoder_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import sse_pkg::*;
	logic clk = 0, rst = 1, ev_valid = 0, ptr_valid = 0, ptr_cmd = 0;
	logic bit_valid = 0, retry_valid = 0, reg_wr = 0, reg_rd = 0, rd_d = 0;
	sse_event_type ev_id = SSE_EV_NONE;
	logic [15:0] ptr_first = 0, ptr_last = 0, retry_count = 0, got_count;
	logic [2:0] bit_pos = 0;
	logic [7:0] reg_addr = 0, sense_code, sense_qual;
	logic [7:0] sense_b15, sense_b16, sense_b17;
	logic [31:0] reg_wdata = 0, reg_rdata;
	logic [3:0] sense_key;
	logic sense_update, super_on = 0;
	logic [43:0] last_sense, last_exp = 0, sq[$];
	logic [31:0] rq[$];
	int failures = 0, cmp_count = 0, sent = 0;
	// Code and qualifier per event number
	logic [15:0] tbl [0:23] = '{16'h0000, 16'h0C01, 16'h0200, 16'h0300,
		16'h0396, 16'h0397, 16'h0980, 16'h0981, 16'h1000, 16'h1200,
		16'h1300, 16'h1401, 16'h1500, 16'h1701, 16'h1702, 16'h1800,
		16'h1801, 16'h1802, 16'h448A, 16'h4486, 16'h4495, 16'h4497,
		16'h1C00, 16'h1800};
	always #2 clk = ~clk;
	sse_encoder uut (.clk, .rst, .ev_valid, .ev_id, .ptr_valid, .ptr_cmd,
		.ptr_first, .ptr_last, .bit_valid, .bit_pos, .retry_valid,
		.retry_count, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.sense_key, .sense_code, .sense_qual, .sense_b15, .sense_b16,
		.sense_b17, .sense_update);
	sse_initiator host (.clk, .rst, .sense_update, .sense_key, .sense_code,
		.sense_qual, .sense_b15, .sense_b16, .sense_b17, .got_count,
		.last_sense);
	// Compare and count
	task automatic chk(input logic [43:0] got, input logic [43:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One event with random pointer data, left asserted
	task automatic ev(input logic [4:0] id);
		logic pv, cmd, bv, rv;
		logic [2:0] bp;
		logic [15:0] a, b, rc, pair;
		{pv, cmd, bv, rv, bp} = 7'($urandom);
		a = 16'($urandom);
		b = 16'($urandom);
		rc = 16'($urandom);
		pair = (id == 5'h17 && super_on) ? 16'hAF00 : tbl[id % 24];
		@(posedge clk);
		{ev_valid, ptr_valid, ptr_cmd} <= {1'b1, pv, cmd};
		{bit_valid, retry_valid} <= {bv, rv};
		// Codes past the table still reach the pins as raw bits
		ev_id <= sse_event_type'(id);
		{bit_pos, ptr_first, ptr_last, retry_count} <= {bp, a, b, rc};
		// Bit position only stands while its valid flag is set
		last_exp = {4'h1, pair,
			pv ? {1'b1, cmd, 2'b00, bv, bv ? bp : 3'h0} : {rv, 7'h00},
			pv ? (a < b ? a : b) : (rv ? rc : 16'h0000)};
		if (id == 5'h00 || id > 5'h17)
			last_exp = 44'h0;
		sq.push_back(last_exp);
		sent++;
	endtask
	task automatic stop();
		@(posedge clk);
		ev_valid <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		{reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		{reg_rd, reg_addr} <= {1'b1, a};
		rq.push_back(e);
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask
	// Results taken off the queues as they appear
	always @(posedge clk) rd_d <= reg_rd;
	always @(negedge clk) begin
		if (sense_update === 1'b1)
			chk({sense_key, sense_code, sense_qual, sense_b15, sense_b16,
				sense_b17}, sq.pop_front());
		if (rd_d)
			chk({12'h0, reg_rdata}, {12'h0, rq.pop_front()});
	end
	task automatic final_report();
		$display("failures %0d comparisons %0d", failures, cmp_count);
		if (failures == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		void'($urandom(32'hE788B50D));
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 27; i++) ev(5'(i % 26));
		stop();
		rd(8'h04, {12'h0, last_exp[43:24]});
		rd(8'h08, {8'h0, last_exp[23:0]});
		rd(8'h0C, 32'h0);
		wr(8'h00, 32'h1);
		super_on = 1'b1;
		rd(8'h00, 32'h1);
		ev(5'h17);
		stop();
		rd(8'h04, {12'h0, last_exp[43:24]});
		rd(8'h08, {8'h0, last_exp[23:0]});
		wr(8'h00, 32'h2);
		super_on = 1'b0;
		rd(8'h04, 32'h0);
		rd(8'h08, 32'h0);
		rd(8'h00, 32'h0);
		repeat (60) ev(5'($urandom_range(0, 23)));
		stop();
		repeat (3) @(posedge clk);
		chk({28'h0, got_count}, 44'(sent));
		chk(last_sense, last_exp);
		final_report();
	end
	initial begin
		#20us;
		failures++;
		final_report();
	end
endmodule
bind sse_encoder sse_encoder_sva #(.PTR_W(PTR_W)) sva_i (.clk, .rst,
	.ev_valid, .ev_id, .ptr_valid, .ptr_cmd, .ptr_first, .ptr_last,
	.bit_valid, .bit_pos, .retry_valid, .retry_count, .sense_key,
	.sense_code, .sense_qual, .sense_b15, .sense_b16, .sense_b17,
	.sense_update);
`default_nettype wire
